// *** src/cmpctl_regs.sv ***
// Summary of operation
// - Control two bit 1 picks the raw or the filtered comparator result.
// - Control two bit 2 connects analog pin a to the comparator.
// - Control two bit 3 connects analog pin b to the comparator.
// - Control two bits 4 to 7 are plain read/write storage with no effect.
// - The flag sets on a rising result edge with edge select 0, falling with 1.
// - Control one bit 3 powers the comparator on.
// - Reference field 0 off, 1 quarter supply, 2 half supply, 3 diode.
// - Control one bit 6 chooses which input path gets the reference.
// - The reference node is driven only while the reference code is nonzero.
// - Control one bit 7 swaps the two comparator inputs.
// - Eight port-disable bits each switch off one port input buffer.
// - Port-disable bits reset to zero so all input buffers start enabled.
`timescale 1ns/1ps
module cmpctl_regs
  import cmpctl_pkg::*;
#(
  parameter int FILT_TAPS = FILTER_TAPS
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              cmp_raw_in,
  output logic                   cmp_power_on,
  output logic [1:0]             ref_level_select,
  output logic                   ref_path_select,
  output logic                   ref_drive_enable,
  output logic                   input_swap,
  output logic                   pin_a_connect,
  output logic                   pin_b_connect,
  output logic [7:0]             port_buffer_disable,
  output logic                   cmp_irq
);
  logic [7:0]        comparator_control_one;
  logic [7:0]        comparator_control_two;
  logic [7:0]        port_bits;
  logic [7:0]        next_ctl_one;
  logic [7:0]        next_ctl_two;
  logic [7:0]        next_port_bits;
  logic              raw_meta;
  logic              raw_sync;
  logic              filt_out;
  logic              cmp_result_bit;
  logic              result_prev;
  logic              next_result_prev;
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [7:0]        w_byte;
  logic              w_lane0;
  logic              next_aw_held;
  logic              next_w_held;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [7:0]        next_w_byte;
  logic              next_w_lane0;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_rvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic              wr_fire;
  logic              edge_seen;

  // analog result comes from outside the clock domain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_meta <= 1'b0;
      raw_sync <= 1'b0;
    end else begin
      raw_meta <= cmp_raw_in;
      raw_sync <= raw_meta;
    end
  end

  cmpctl_filter #(
    .TAPS (FILT_TAPS)
  ) u_filter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (raw_sync),
    .dout    (filt_out)
  );

  assign cmp_result_bit = comparator_control_two[FILTER_SEL_BIT] ? filt_out : raw_sync;

  assign edge_seen = comparator_control_one[EDGE_SEL_BIT] ? (result_prev & ~cmp_result_bit)
                                                          : (~result_prev & cmp_result_bit);

  // axi write: address and data accepted in either order, one outstanding
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_byte  = w_byte;
    next_w_lane0 = w_lane0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held  = 1'b1;
      next_w_byte  = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
    end
  end

  assign wr_fire = aw_held && w_held;

  // register file update; hardware flag set beats the software clear
  always_comb begin
    next_ctl_one     = comparator_control_one;
    next_ctl_two     = comparator_control_two;
    next_port_bits   = port_bits;
    next_result_prev = cmp_result_bit;
    next_bvalid      = s_axi_bvalid;
    next_bresp       = s_axi_bresp;
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_bvalid = 1'b1;
      next_bresp  = AXI_OKAY;
      case (aw_addr)
        CONTROL_ONE_ADDR: begin
          if (w_lane0) begin
            next_ctl_one = w_byte;
          end
        end
        CONTROL_TWO_ADDR: begin
          if (w_lane0) begin
            next_ctl_two = {w_byte[7:1], 1'b0};
          end
        end
        PORT_DISABLE_ADDR: begin
          if (w_lane0) begin
            next_port_bits = w_byte;
          end
        end
        default: begin
          next_bresp = AXI_SLVERR;
        end
      endcase
    end
    if (edge_seen) begin
      next_ctl_one[IRQ_FLAG_BIT] = 1'b1;
    end
  end

  // read path: data registered, unmapped answers slverr
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = AXI_OKAY;
      next_rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        CONTROL_ONE_ADDR: next_rdata[7:0] = comparator_control_one;
        CONTROL_TWO_ADDR: next_rdata[7:0] = {comparator_control_two[7:1], cmp_result_bit};
        PORT_DISABLE_ADDR: next_rdata[7:0] = port_bits;
        default: next_rresp = AXI_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comparator_control_one <= CONTROL_ONE_RST;
      comparator_control_two <= CONTROL_TWO_RST;
      port_bits              <= PORT_DISABLE_RST;
      result_prev            <= 1'b0;
      aw_held                <= 1'b0;
      w_held                 <= 1'b0;
      aw_addr                <= '0;
      w_byte                 <= 8'h00;
      w_lane0                <= 1'b0;
      s_axi_bvalid           <= 1'b0;
      s_axi_bresp            <= AXI_OKAY;
      s_axi_rvalid           <= 1'b0;
      s_axi_rdata            <= 32'h0000_0000;
      s_axi_rresp            <= AXI_OKAY;
    end else begin
      comparator_control_one <= next_ctl_one;
      comparator_control_two <= next_ctl_two;
      port_bits              <= next_port_bits;
      result_prev            <= next_result_prev;
      aw_held                <= next_aw_held;
      w_held                 <= next_w_held;
      aw_addr                <= next_aw_addr;
      w_byte                 <= next_w_byte;
      w_lane0                <= next_w_lane0;
      s_axi_bvalid           <= next_bvalid;
      s_axi_bresp            <= next_bresp;
      s_axi_rvalid           <= next_rvalid;
      s_axi_rdata            <= next_rdata;
      s_axi_rresp            <= next_rresp;
    end
  end

  // analog controls straight from the stored bits
  // power enable
  assign cmp_power_on     = comparator_control_one[POWER_ON_BIT];
  assign ref_level_select = comparator_control_one[REF_LEVEL_LSB +: 2];
  assign ref_path_select  = comparator_control_one[REF_PATH_BIT];
  assign ref_drive_enable = (comparator_control_one[REF_LEVEL_LSB +: 2] != REF_OFF);
  assign input_swap       = comparator_control_one[INPUT_SWAP_BIT];
  assign pin_a_connect    = comparator_control_two[PIN_A_BIT];
  assign pin_b_connect    = comparator_control_two[PIN_B_BIT];
  assign port_buffer_disable = port_bits;
  assign cmp_irq = comparator_control_one[IRQ_FLAG_BIT] & comparator_control_one[IRQ_ENABLE_BIT];

  spare_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && aw_addr == CONTROL_TWO_ADDR && w_lane0) |=>
      comparator_control_two[7:4] == $past(w_byte[7:4]))
    else $error("spare bits not stored");
  flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    edge_seen |=> comparator_control_one[IRQ_FLAG_BIT])
    else $error("edge lost");
  flag_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (comparator_control_one[IRQ_FLAG_BIT] && !wr_fire) |=>
      comparator_control_one[IRQ_FLAG_BIT])
    else $error("flag dropped");
  flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && aw_addr == CONTROL_ONE_ADDR && w_lane0 && !w_byte[IRQ_FLAG_BIT] && !edge_seen)
      |=> !comparator_control_one[IRQ_FLAG_BIT])
    else $error("flag not cleared");
  irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmp_irq == (comparator_control_one[0] && comparator_control_one[1]))
    else $error("irq gating wrong");
  ref_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ref_drive_enable == (ref_level_select != 2'h0))
    else $error("reference drive wrong");
  result_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !comparator_control_two[FILTER_SEL_BIT] |-> cmp_result_bit == raw_sync)
    else $error("unfiltered path wrong");
  result_ro_a: assert property (@(posedge aclk) disable iff (!aresetn)
    comparator_control_two[RESULT_BIT] == 1'b0)
    else $error("result bit stored");
  port_reset_a: assert property (@(posedge aclk)
    !aresetn |=> port_buffer_disable == 8'h00)
    else $error("port bits not cleared");
  pin_conn_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && aw_addr == CONTROL_TWO_ADDR && w_lane0) |=>
      pin_a_connect == $past(w_byte[2]) && pin_b_connect == $past(w_byte[3]))
    else $error("pin connect wrong");
  wr_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid)
    else $error("write response missing");

  irq_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(cmp_irq));
  fall_cov_c: cover property (@(posedge aclk) disable iff (!aresetn)
    edge_seen && comparator_control_one[EDGE_SEL_BIT]);
  filt_cov_c: cover property (@(posedge aclk) disable iff (!aresetn)
    comparator_control_two[FILTER_SEL_BIT] && $changed(filt_out));
  rd_cov_c: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rresp == AXI_SLVERR);
endmodule

// *** src/cmpctl_pkg.sv ***
package cmpctl_pkg;
  // printed offsets are not all multiples of four, so they are register indexes
  localparam logic [7:0]  CONTROL_ONE_IDX   = 8'h59;
  localparam logic [7:0]  CONTROL_TWO_IDX   = 8'h5A;
  localparam logic [7:0]  PORT_DISABLE_IDX  = 8'h5B;
  localparam int          ADDR_W            = 12;
  localparam logic [11:0] CONTROL_ONE_ADDR  = {2'h0, CONTROL_ONE_IDX, 2'h0};
  localparam logic [11:0] CONTROL_TWO_ADDR  = {2'h0, CONTROL_TWO_IDX, 2'h0};
  localparam logic [11:0] PORT_DISABLE_ADDR = {2'h0, PORT_DISABLE_IDX, 2'h0};

  // control one fields
  localparam int IRQ_FLAG_BIT   = 0;
  localparam int IRQ_ENABLE_BIT = 1;
  localparam int EDGE_SEL_BIT   = 2;
  localparam int POWER_ON_BIT   = 3;
  localparam int REF_LEVEL_LSB  = 4;
  localparam int REF_PATH_BIT   = 6;
  localparam int INPUT_SWAP_BIT = 7;
  // control two fields
  localparam int RESULT_BIT     = 0;
  localparam int FILTER_SEL_BIT = 1;
  localparam int PIN_A_BIT      = 2;
  localparam int PIN_B_BIT      = 3;

  // reset values
  localparam logic [7:0] CONTROL_ONE_RST  = 8'h00;
  localparam logic [7:0] CONTROL_TWO_RST  = 8'h00;
  localparam logic [7:0] PORT_DISABLE_RST = 8'h00;

  // filter length in cycles
  localparam int FILTER_TAPS = 4;

  // reference level codes
  typedef enum logic [1:0] {
    REF_OFF,
    REF_QUARTER,
    REF_HALF,
    REF_DIODE
  } cmpctl_ref_e;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// *** src/cmpctl_filter.sv ***
`timescale 1ns/1ps
// majority-free filter: output moves only after TAPS equal samples
module cmpctl_filter
  import cmpctl_pkg::*;
#(
  parameter int TAPS = FILTER_TAPS
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic din,
  output logic      dout
);
  logic [TAPS-1:0] hist;
  logic [TAPS-1:0] next_hist;
  logic            next_dout;

  // elaboration guard: a window below two samples cannot filter anything
  if (TAPS < 2 || TAPS > 16) begin : g_bad_taps
    $error("filter taps out of range");
  end

  // shift in, settle only when the window agrees
  always_comb begin
    next_hist = {hist[TAPS-2:0], din};
    next_dout = dout;
    if (&next_hist) begin
      next_dout = 1'b1;
    end else if (~|next_hist) begin
      next_dout = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hist <= '0;
      dout <= 1'b0;
    end else begin
      hist <= next_hist;
      dout <= next_dout;
    end
  end
endmodule

// *** testbench/cmpctl_analog_model.sv ***
`timescale 1ns/1ps
// far-side stand-in: analog comparator core seen as one digital level
module cmpctl_analog_model (
  input  wire logic aclk,
  input  wire logic cmp_power_on,
  input  wire logic input_swap,
  input  wire logic level_hi,
  output logic      cmp_raw_in
);
  // powered-off core rests low; swap flips the comparison sense
  always_ff @(posedge aclk) begin
    cmp_raw_in <= cmp_power_on & (level_hi ^ input_swap);
  end
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb;
  import cmpctl_pkg::*;
  logic              aclk = 1'h0;
  logic              aresetn = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'h1;
  logic [1:0]        s_axi_bresp, s_axi_rresp, ref_level_select;
  logic              s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic              s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, level_hi = 1'h0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic              cmp_raw_in, cmp_power_on, ref_path_select, ref_drive_enable, input_swap;
  logic              pin_a_connect, pin_b_connect, cmp_irq;
  logic [7:0]        port_buffer_disable;
  int                failures = 0, n_compared = 0;

  // 250 MHz clock
  always #2 aclk = ~aclk;

  cmpctl_regs #(.FILT_TAPS(4)) uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_raw_in, .cmp_power_on,
    .ref_level_select, .ref_path_select, .ref_drive_enable, .input_swap,
    .pin_a_connect, .pin_b_connect, .port_buffer_disable, .cmp_irq
  );

  cmpctl_analog_model model (.aclk, .cmp_power_on, .input_swap, .level_hi, .cmp_raw_in);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = AXI_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'h0;
    // idle edge so a following call never re-raises bready in this step
    @(posedge aclk);
  endtask

  // read and compare the byte and the response
  task automatic rd(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er = AXI_OKAY);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, {24'h0, ed});
    chk(s_axi_rresp, er);
    s_axi_rready <= 1'h0;
    // idle edge so a following call never re-raises rready in this step
    @(posedge aclk);
  endtask

  // short pulse on the analog level, then settle
  task automatic glitch;
    level_hi <= 1'h1;
    cyc(2);
    level_hi <= 1'h0;
    cyc(12);
  endtask

  task automatic t_reset;
    rd(CONTROL_ONE_ADDR, 8'h00);
    rd(CONTROL_TWO_ADDR, 8'h00);
    rd(PORT_DISABLE_ADDR, 8'h00);
    chk(port_buffer_disable, 8'h00);
    rd(12'h170, 8'h00, AXI_SLVERR);
    wr(12'h170, 8'hFF, AXI_SLVERR);
    $display("reset and map test done");
  endtask

  // every reference code with path and swap varied alongside
  task automatic t_ctl1;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      wr(CONTROL_ONE_ADDR, {c[0], c[1], c, 4'h8});
      chk(cmp_power_on, 1'h1);
      chk(ref_level_select, c);
      chk(ref_drive_enable, c != 2'h0);
      chk(ref_path_select, c[1]);
      chk(input_swap, c[0]);
    end
    wr(CONTROL_ONE_ADDR, 8'h00);
    cyc(6);
    chk(cmp_power_on, 1'h0);
    // a powered core with swapped inputs raised the result, so the flag may be set
    wr(CONTROL_ONE_ADDR, 8'h00);
    rd(CONTROL_ONE_ADDR, 8'h00);
    $display("control one test done");
  endtask

  task automatic t_ctl2;
    wr(CONTROL_TWO_ADDR, 8'hA5);
    chk({pin_a_connect, pin_b_connect}, 2'h2);
    rd(CONTROL_TWO_ADDR, 8'hA4);
    wr(CONTROL_TWO_ADDR, 8'h58);
    chk({pin_a_connect, pin_b_connect}, 2'h1);
    rd(CONTROL_TWO_ADDR, 8'h58);
    wr(CONTROL_TWO_ADDR, 8'h00);
    $display("control two test done");
  endtask

  task automatic t_port;
    wr(PORT_DISABLE_ADDR, 8'h96);
    chk(port_buffer_disable, 8'h96);
    wr(PORT_DISABLE_ADDR, 8'h69);
    rd(PORT_DISABLE_ADDR, 8'h69);
    chk(port_buffer_disable, 8'h69);
    // a write with lane zero off leaves the register alone
    s_axi_wstrb <= 4'h0;
    wr(PORT_DISABLE_ADDR, 8'hFF);
    s_axi_wstrb <= 4'h1;
    chk(port_buffer_disable, 8'h69);
    $display("port disable test done");
  endtask

  // reset in mid-run clears the port bits that were set
  task automatic t_rst_mid;
    aresetn <= 1'h0;
    cyc(3);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk(port_buffer_disable, 8'h00);
    rd(PORT_DISABLE_ADDR, 8'h00);
    $display("mid-run reset test done");
  endtask

  // edge select both ways, enable masking, flag held until cleared
  task automatic t_flag;
    wr(CONTROL_ONE_ADDR, 8'h0A);
    level_hi <= 1'h1;
    cyc(12);
    chk(cmp_irq, 1'h1);
    rd(CONTROL_TWO_ADDR, 8'h01);
    rd(CONTROL_ONE_ADDR, 8'h0B);
    wr(CONTROL_ONE_ADDR, 8'h0A);
    rd(CONTROL_ONE_ADDR, 8'h0A);
    level_hi <= 1'h0;
    cyc(12);
    chk(cmp_irq, 1'h0);
    wr(CONTROL_ONE_ADDR, 8'h0E);
    level_hi <= 1'h1;
    cyc(12);
    chk(cmp_irq, 1'h0);
    level_hi <= 1'h0;
    cyc(12);
    chk(cmp_irq, 1'h1);
    wr(CONTROL_ONE_ADDR, 8'h0D);
    chk(cmp_irq, 1'h0);
    cyc(20);
    rd(CONTROL_ONE_ADDR, 8'h0D);
    $display("flag test done");
  endtask

  // a two-cycle pulse passes the raw path only
  task automatic t_filter;
    wr(CONTROL_ONE_ADDR, 8'h0A);
    wr(CONTROL_TWO_ADDR, 8'h02);
    glitch;
    chk(cmp_irq, 1'h0);
    rd(CONTROL_TWO_ADDR, 8'h02);
    // a steady level still gets through the filter
    level_hi <= 1'h1;
    cyc(12);
    rd(CONTROL_TWO_ADDR, 8'h03);
    chk(cmp_irq, 1'h1);
    level_hi <= 1'h0;
    cyc(12);
    wr(CONTROL_ONE_ADDR, 8'h0A);
    wr(CONTROL_TWO_ADDR, 8'h00);
    glitch;
    chk(cmp_irq, 1'h1);
    $display("filter test done");
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // main sequence after a three-cycle reset
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset;
    t_ctl1;
    t_ctl2;
    t_port;
    t_rst_mid;
    t_flag;
    t_filter;
    test_done;
  end

  // the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    failures++;
    test_done;
  end
endmodule
